// File: core/tct_core.sv
// Conversion sequencer, result store, trip points and thermostat output.
// Assumes the converter code and host command strobes come from logic on clk.
`timescale 1ns/1ps

module tct_core #(
    parameter bit AUTO_START = 1'b0,
    parameter int unsigned CONV9_CYC = tct_pkg::CONV9_CYCLES,
    parameter int unsigned NV_WR_CYC = tct_pkg::NV_WRITE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Host command port
    input wire logic cmd_valid,
    input wire tct_pkg::tct_cmd_t cmd_code,
    input wire logic cmd_write,
    input wire logic [15:0] cmd_wdata,
    output logic [15:0] cmd_rdata,
    output logic cmd_rvalid,
    // Converter result, 12-bit two's complement in 1/16 degree
    input wire logic [11:0] adc_code,
    // Status and thermostat pins
    output logic converting,
    output logic thermostat_out
);
    import tct_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    tct_state_t state_reg;
    logic continuous_reg;
    logic [25:0] conv_cnt_reg;
    logic [15:0] temp_reg;
    logic [15:0] upper_trip_reg;
    logic [15:0] lower_trip_reg;
    logic [1:0] res_reg;
    logic pol_reg;
    logic single_reg;
    logic high_flag_reg;
    logic low_flag_reg;
    logic [18:0] nv_cnt_reg;
    logic nv_busy;
    logic therm_active_reg;
    logic [15:0] res_mask;
    logic [25:0] conv_len;
    logic [15:0] new_temp;
    logic conv_done;
    logic begin_cmd;
    logic halt_cmd;
    logic nv_write;
    logic setup_write;
    logic [7:0] setup_view;

    // ----------------------------------------------------------------
    // Resolution and command decode
    // ----------------------------------------------------------------
    // Mask of the active result bits for the selected resolution
    always_comb begin
        case (res_reg)
            2'b00: res_mask = MASK_9;
            2'b01: res_mask = MASK_10;
            2'b10: res_mask = MASK_11;
            default: res_mask = MASK_12;
        endcase
    end

    // Base length shifted left by the resolution code doubles per bit
    assign conv_len = 26'(CONV9_CYC) << res_reg;

    // Code shifted left by four lands in bits 15..4, bit 14 weighs 2^6
    assign new_temp = {adc_code, 4'h0} & res_mask;

    assign conv_done = (state_reg == TCT_CONVERT) && (conv_cnt_reg == 26'h0000001);
    assign begin_cmd = cmd_valid && (cmd_code == TCT_CMD_BEGIN);
    assign halt_cmd = cmd_valid && (cmd_code == TCT_CMD_HALT);
    assign nv_busy = (nv_cnt_reg != 19'h00000);
    assign setup_write = cmd_valid && cmd_write && (cmd_code == TCT_CMD_SETUP);
    // Nonvolatile writes are refused while a previous one is still busy
    assign nv_write = cmd_valid && cmd_write && !nv_busy &&
        ((cmd_code == TCT_CMD_HIGH_TRIP) || (cmd_code == TCT_CMD_LOW_TRIP) ||
        ((cmd_code == TCT_CMD_SETUP) &&
        ({cmd_wdata[SETUP_POL_BIT], cmd_wdata[SETUP_SINGLE_BIT]} != {pol_reg, single_reg})));

    // ----------------------------------------------------------------
    // Conversion sequencer
    // ----------------------------------------------------------------
    // Idle or converting; auto variant starts out converting
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= AUTO_START ? TCT_CONVERT : TCT_IDLE;
        end else begin
            case (state_reg)
                TCT_IDLE: begin
                    if (begin_cmd) begin
                        state_reg <= TCT_CONVERT;
                    end
                end
                TCT_CONVERT: begin
                    // Halt aborts; a begin here is ignored
                    if (halt_cmd) begin
                        state_reg <= TCT_IDLE;
                    end else if (conv_done && !continuous_reg) begin
                        state_reg <= TCT_IDLE;
                    end
                end
                default: state_reg <= TCT_IDLE;
            endcase
        end
    end

    // Mode is latched at the start so a setup change cannot split a run
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            continuous_reg <= !SINGLE_FACTORY;
        end else if (state_reg == TCT_IDLE && begin_cmd) begin
            continuous_reg <= !single_reg;
        end
    end

    // Conversion timer, reloaded for each back to back conversion
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            conv_cnt_reg <= 26'(CONV9_CYC) << RES_RESET;
        end else if (state_reg == TCT_IDLE) begin
            conv_cnt_reg <= conv_len;
        end else if (conv_done) begin
            conv_cnt_reg <= conv_len;
        end else begin
            conv_cnt_reg <= conv_cnt_reg - 26'h0000001;
        end
    end

    // ----------------------------------------------------------------
    // Result and thermostat
    // ----------------------------------------------------------------
    // Result register, written only at completion
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            temp_reg <= TEMP_RESET;
        end else if (conv_done) begin
            temp_reg <= new_temp;
        end
    end

    // Hysteresis decided only at completion, held otherwise
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            therm_active_reg <= 1'b0;
        end else if (conv_done) begin
            if ($signed(new_temp) >= $signed(upper_trip_reg & res_mask)) begin
                therm_active_reg <= 1'b1;
            end else if ($signed(new_temp) < $signed(lower_trip_reg & res_mask)) begin
                therm_active_reg <= 1'b0;
            end
        end
    end

    // Polarity applied after the decision; output one clock behind
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            thermostat_out <= !POL_FACTORY;
        end else begin
            thermostat_out <= pol_reg ? therm_active_reg : !therm_active_reg;
        end
    end

    // Sticky excursion flags; a set in the clearing cycle wins
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            high_flag_reg <= 1'b0;
            low_flag_reg <= 1'b0;
        end else begin
            if (conv_done && $signed(new_temp) > $signed(upper_trip_reg & res_mask)) begin
                high_flag_reg <= 1'b1;
            end else if (setup_write && !cmd_wdata[SETUP_HIGH_FLAG_BIT]) begin
                high_flag_reg <= 1'b0;
            end
            if (conv_done && $signed(new_temp) < $signed(lower_trip_reg & res_mask)) begin
                low_flag_reg <= 1'b1;
            end else if (setup_write && !cmd_wdata[SETUP_LOW_FLAG_BIT]) begin
                low_flag_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Setup and nonvolatile storage
    // ----------------------------------------------------------------
    // Volatile resolution bits are written immediately
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            res_reg <= RES_RESET;
        end else if (setup_write) begin
            res_reg <= {cmd_wdata[SETUP_RES_HI_BIT], cmd_wdata[SETUP_RES_LO_BIT]};
        end
    end

    // Nonvolatile cells; reset stands in for the shipped contents
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            upper_trip_reg <= UPPER_TRIP_FACTORY;
            lower_trip_reg <= LOWER_TRIP_FACTORY;
            pol_reg <= POL_FACTORY;
            single_reg <= SINGLE_FACTORY;
        end else if (nv_write) begin
            case (cmd_code)
                TCT_CMD_HIGH_TRIP: upper_trip_reg <= cmd_wdata;
                TCT_CMD_LOW_TRIP: lower_trip_reg <= cmd_wdata;
                default: begin
                    pol_reg <= cmd_wdata[SETUP_POL_BIT];
                    single_reg <= cmd_wdata[SETUP_SINGLE_BIT];
                end
            endcase
        end
    end

    // Busy time of a write; the worst case bounds the cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            nv_cnt_reg <= 19'h00000;
        end else if (nv_write) begin
            nv_cnt_reg <= 19'(NV_WR_CYC);
        end else if (nv_busy) begin
            nv_cnt_reg <= nv_cnt_reg - 19'h00001;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Status view; done bit low while a conversion runs
    always_comb begin
        setup_view = 8'h00;
        setup_view[SETUP_DONE_BIT] = (state_reg == TCT_IDLE);
        setup_view[SETUP_HIGH_FLAG_BIT] = high_flag_reg;
        setup_view[SETUP_LOW_FLAG_BIT] = low_flag_reg;
        setup_view[SETUP_NV_BUSY_BIT] = nv_busy;
        setup_view[SETUP_RES_HI_BIT] = res_reg[1];
        setup_view[SETUP_RES_LO_BIT] = res_reg[0];
        setup_view[SETUP_POL_BIT] = pol_reg;
        setup_view[SETUP_SINGLE_BIT] = single_reg;
    end

    // Read data one clock after the command, valid for one cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cmd_rdata <= 16'h0000;
            cmd_rvalid <= 1'b0;
        end else begin
            cmd_rvalid <= cmd_valid && !cmd_write && (cmd_code != TCT_CMD_BEGIN) &&
                (cmd_code != TCT_CMD_HALT);
            if (cmd_valid && !cmd_write && (cmd_code != TCT_CMD_BEGIN) && (cmd_code != TCT_CMD_HALT)) begin
                case (cmd_code)
                    TCT_CMD_READ_TEMP: cmd_rdata <= temp_reg;
                    TCT_CMD_HIGH_TRIP: cmd_rdata <= upper_trip_reg & res_mask;
                    TCT_CMD_LOW_TRIP: cmd_rdata <= lower_trip_reg & res_mask;
                    TCT_CMD_SETUP: cmd_rdata <= {8'h00, setup_view};
                    default: cmd_rdata <= 16'h0000;
                endcase
            end
        end
    end

    // Conversion activity pin
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            converting <= 1'b0;
        end else begin
            converting <= (state_reg == TCT_CONVERT);
        end
    end

endmodule

// File: core/tct_pkg.sv
// Shared constants of the temperature conversion and thermostat core.
// Assumes a single 40 MHz clock; times are converted to cycle counts here.
package tct_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 40;
    localparam int unsigned T_CONV9_MAX_US = 93750;
    localparam int unsigned T_NV_WRITE_MAX_US = 10000;
    localparam int unsigned CONV9_CYCLES = T_CONV9_MAX_US * CLK_MHZ;
    localparam int unsigned NV_WRITE_CYCLES = T_NV_WRITE_MAX_US * CLK_MHZ;

    // ----------------------------------------------------------------
    // Host commands
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        TCT_CMD_BEGIN = 3'b000,
        TCT_CMD_HALT = 3'b001,
        TCT_CMD_READ_TEMP = 3'b010,
        TCT_CMD_HIGH_TRIP = 3'b011,
        TCT_CMD_LOW_TRIP = 3'b100,
        TCT_CMD_SETUP = 3'b101
    } tct_cmd_t;

    // ----------------------------------------------------------------
    // Setup and status field positions
    // ----------------------------------------------------------------
    localparam int unsigned SETUP_DONE_BIT = 7;
    localparam int unsigned SETUP_HIGH_FLAG_BIT = 6;
    localparam int unsigned SETUP_LOW_FLAG_BIT = 5;
    localparam int unsigned SETUP_NV_BUSY_BIT = 4;
    localparam int unsigned SETUP_RES_HI_BIT = 3;
    localparam int unsigned SETUP_RES_LO_BIT = 2;
    localparam int unsigned SETUP_POL_BIT = 1;
    localparam int unsigned SETUP_SINGLE_BIT = 0;

    // ----------------------------------------------------------------
    // Reset and factory values
    // ----------------------------------------------------------------
    localparam logic [15:0] TEMP_RESET = 16'hc400;
    localparam logic [15:0] UPPER_TRIP_FACTORY = 16'h0f00;
    localparam logic [15:0] LOWER_TRIP_FACTORY = 16'h0a00;
    localparam logic [1:0] RES_RESET = 2'b11;
    localparam logic POL_FACTORY = 1'b0;
    localparam logic SINGLE_FACTORY = 1'b0;

    // ----------------------------------------------------------------
    // Result masks per resolution code (9, 10, 11, 12 bits)
    // ----------------------------------------------------------------
    localparam logic [15:0] MASK_9 = 16'hff80;
    localparam logic [15:0] MASK_10 = 16'hffc0;
    localparam logic [15:0] MASK_11 = 16'hffe0;
    localparam logic [15:0] MASK_12 = 16'hfff0;

    // ----------------------------------------------------------------
    // Sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [0:0] {
        TCT_IDLE = 1'b0,
        TCT_CONVERT = 1'b1
    } tct_state_t;

endpackage

// File: sim/tct_core_sva.sv
// Port-level checker for the temperature conversion and thermostat core.
// Assumes one clock domain and the registered command answers of the core.
`timescale 1ns/1ps

module tct_core_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Command port
    input wire logic cmd_valid,
    input wire tct_pkg::tct_cmd_t cmd_code,
    input wire logic cmd_write,
    input wire logic [15:0] cmd_wdata,
    input wire logic [15:0] cmd_rdata,
    input wire logic cmd_rvalid,
    // Converter and pins
    input wire logic [11:0] adc_code,
    input wire logic converting,
    input wire logic thermostat_out
);
    import tct_pkg::*;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // ----------------------------------------
    // Command classes
    // ----------------------------------------
    // A read of temp written as a write is left out of both classes
    wire logic is_rd = cmd_valid && !cmd_write && cmd_code inside {TCT_CMD_READ_TEMP, TCT_CMD_HIGH_TRIP,
        TCT_CMD_LOW_TRIP, TCT_CMD_SETUP};
    wire logic no_ans = !cmd_valid || cmd_code inside {TCT_CMD_BEGIN, TCT_CMD_HALT} ||
        (cmd_write && cmd_code != TCT_CMD_READ_TEMP);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    read_answer_a: assert property (is_rd |=> cmd_rvalid)
        else $error("read not answered");
    no_answer_a: assert property (no_ans |=> !cmd_rvalid)
        else $error("answer without read");
    rdata_hold_a: assert property (!cmd_rvalid |-> $stable(cmd_rdata))
        else $error("read data moved");
    low_nibble_a: assert property (cmd_rvalid && $past(cmd_code) != TCT_CMD_SETUP |-> cmd_rdata[3:0] == 4'h0)
        else $error("low nibble not zero");
    setup_read_a: assert property (cmd_rvalid && $past(cmd_code) == TCT_CMD_SETUP
        |-> cmd_rdata[15:8] == 8'h00 && cmd_rdata[7] == !converting)
        else $error("setup read wrong");
    begin_runs_a: assert property (cmd_valid && cmd_code == TCT_CMD_BEGIN ##1
        !(cmd_valid && cmd_code == TCT_CMD_HALT) |=> converting)
        else $error("begin did not start");
    halt_idles_a: assert property (cmd_valid && cmd_code == TCT_CMD_HALT ##1
        !(cmd_valid && cmd_code == TCT_CMD_BEGIN) |=> !converting)
        else $error("halt did not stop");
    conv_floor_a: assert property ($rose(converting) |-> converting[*6])
        else $error("conversion too short");
    reset_vals_a: assert property (disable iff (1'b0)
        !rstn |-> !converting && !cmd_rvalid && cmd_rdata == 16'h0000)
        else $error("reset values wrong");

    // Main scenarios reached
    cover property (cmd_valid && cmd_code == TCT_CMD_HALT && converting);
    cover property (cmd_rvalid && $past(cmd_code) == TCT_CMD_SETUP);
    cover property ($fell(converting));
endmodule

bind tct_core tct_core_sva tct_core_sva_inst (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_write(cmd_write), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
    .cmd_rvalid(cmd_rvalid), .adc_code(adc_code), .converting(converting), .thermostat_out(thermostat_out));

// File: sim/tct_core_test.sv
// Self-checking bench for the temperature conversion and thermostat core.
// Runs the manual-start and auto-start variants with shortened conversion and write times.
`timescale 1ns/1ps

module tct_core_test;
    import tct_pkg::*;
    localparam int C9 = 8;
    logic clk, rstn, cmd_valid, cmd_write, cmd_rvalid, converting, thermostat_out;
    tct_cmd_t cmd_code;
    logic [15:0] cmd_wdata, cmd_rdata, q;
    logic [11:0] adc_code;
    logic [15:0] masks [4] = '{MASK_9, MASK_10, MASK_11, MASK_12};
    logic [15:0] auto_rdata;
    logic auto_rvalid, auto_converting, auto_thermostat;
    int n_errors = 0, check_count = 0, cycles = 0, n, len [4];

    tct_core #(.AUTO_START(1'b0), .CONV9_CYC(C9), .NV_WR_CYC(5)) tct_core_inst (.clk(clk), .rstn(rstn),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_write(cmd_write), .cmd_wdata(cmd_wdata),
        .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid), .adc_code(adc_code), .converting(converting),
        .thermostat_out(thermostat_out));
    // Auto-start variant shares the command port; its activity pin shows the power-up start
    tct_core #(.AUTO_START(1'b1), .CONV9_CYC(C9), .NV_WR_CYC(5)) tct_core_auto_inst (.clk(clk), .rstn(rstn),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_write(cmd_write), .cmd_wdata(cmd_wdata),
        .cmd_rdata(auto_rdata), .cmd_rvalid(auto_rvalid), .adc_code(adc_code), .converting(auto_converting),
        .thermostat_out(auto_thermostat));
    tct_host tct_host_inst (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_write(cmd_write),
        .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid));

    // ----------------------------------------
    // Clock and hang guard
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Whole run needs under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            stop_test();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input tct_cmd_t c, output logic [15:0] r);
        logic v;
        tct_host_inst.xfer(c, 1'b0, 16'h0000, r, v);
        chk1(v, 1'b1);
    endtask
    task automatic wr(input tct_cmd_t c, input logic [15:0] d);
        logic [15:0] r;
        logic v;
        tct_host_inst.xfer(c, 1'b1, d, r, v);
        chk1(v, 1'b0);
    endtask
    // Poll the busy bit; a stuck write shows as a mismatch
    task automatic nv_wait();
        logic [15:0] r;
        int i;
        i = 0;
        rd(TCT_CMD_SETUP, r);
        chk1(r[4], 1'b1);
        while (r[4] === 1'b1 && i < 20) begin
            rd(TCT_CMD_SETUP, r);
            i++;
        end
        chk1(r[4], 1'b0);
    endtask
    task automatic conv(output int n);
        int i;
        i = 0;
        n = 0;
        wr(TCT_CMD_BEGIN, 16'h0000);
        while (converting !== 1'b1 && i < 6) begin
            @(negedge clk);
            i++;
        end
        while (converting === 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic stop_test();
        $display("Checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rstn = 1'b0;
        adc_code = 12'h000;
        repeat (4) @(posedge clk);
        @(negedge clk) rstn = 1'b1;
        rd(TCT_CMD_READ_TEMP, q); chk16(q, 16'hc400);
        rd(TCT_CMD_HIGH_TRIP, q); chk16(q, 16'h0f00);
        rd(TCT_CMD_LOW_TRIP, q); chk16(q, 16'h0a00);
        rd(TCT_CMD_SETUP, q); chk16(q, 16'h008c);
        repeat (20) @(negedge clk);
        chk1(converting, 1'b0);
        chk1(auto_converting, 1'b1);
        chk1(thermostat_out, 1'b1);
        // Single shot, active high output
        wr(TCT_CMD_SETUP, 16'h000f);
        nv_wait();
        chk1(thermostat_out, 1'b0);
        adc_code = 12'h7d0;
        conv(len[0]);
        rd(TCT_CMD_READ_TEMP, q); chk16(q, 16'h7d00);
        chk1(thermostat_out, 1'b1);
        repeat (20) @(negedge clk);
        chk1(converting, 1'b0);
        chk1(auto_converting, 1'b1);
        rd(TCT_CMD_SETUP, q); chk16(16'(q[7:6]), 16'h0003);
        // Every resolution: alignment, trip masking, doubling time
        for (int r = 0; r < 4; r++) begin
            wr(TCT_CMD_SETUP, 16'h0063 | 16'(r << 2));
            wr(TCT_CMD_HIGH_TRIP, 16'h0fff);
            nv_wait();
            rd(TCT_CMD_HIGH_TRIP, q); chk16(q, 16'h0fff & masks[r]);
            adc_code = 12'hf5e;
            conv(len[r]);
            rd(TCT_CMD_READ_TEMP, q); chk16(q, 16'hf5e0 & masks[r]);
            chk1(thermostat_out, 1'b0);
            if (r > 0) chk16(16'(len[r] - len[r - 1]), 16'(C9 << (r - 1)));
        end
        // Hysteresis band between the trip points
        wr(TCT_CMD_HIGH_TRIP, 16'h1900);
        nv_wait();
        adc_code = 12'h190;
        repeat (10) @(negedge clk);
        chk1(thermostat_out, 1'b0);
        conv(len[0]);
        chk1(thermostat_out, 1'b1);
        adc_code = 12'h0a0;
        conv(len[0]);
        chk1(thermostat_out, 1'b1);
        adc_code = 12'h09f;
        conv(len[0]);
        chk1(thermostat_out, 1'b0);
        // Second begin inside a single-shot run must not stretch it
        wr(TCT_CMD_BEGIN, 16'h0000);
        repeat (20) @(negedge clk);
        wr(TCT_CMD_BEGIN, 16'h0000);
        n = 0;
        while (converting === 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        chk16(16'(n), 16'((C9 << 3) - 21));
        wr(TCT_CMD_SETUP, 16'h000f);
        rd(TCT_CMD_SETUP, q); chk16(q, 16'h008f);
        // Continuous run, begin ignored mid-conversion, halt, restart
        wr(TCT_CMD_SETUP, 16'h000e);
        nv_wait();
        adc_code = 12'h150;
        wr(TCT_CMD_BEGIN, 16'h0000);
        repeat (30) @(negedge clk);
        wr(TCT_CMD_BEGIN, 16'h0000);
        repeat (200) @(negedge clk);
        chk1(converting, 1'b1);
        rd(TCT_CMD_READ_TEMP, q); chk16(q, 16'h1500);
        wr(TCT_CMD_HALT, 16'h0000);
        wr(TCT_CMD_LOW_TRIP, 16'h0800);
        nv_wait();
        rd(TCT_CMD_LOW_TRIP, q); chk16(q, 16'h0800);
        chk1(converting, 1'b0);
        wr(TCT_CMD_BEGIN, 16'h0000);
        repeat (4) @(negedge clk);
        chk1(converting, 1'b1);
        stop_test();
    end
endmodule

// File: sim/tct_host.sv
// Host model that issues commands to the core, one transfer per call.
// Assumes the bench calls xfer hierarchically; drives at falling edges.
`timescale 1ns/1ps

module tct_host (
    // Clock
    input wire logic clk,
    // Command port
    output logic cmd_valid,
    output tct_pkg::tct_cmd_t cmd_code,
    output logic cmd_write,
    output logic [15:0] cmd_wdata,
    input wire logic [15:0] cmd_rdata,
    input wire logic cmd_rvalid
);
    import tct_pkg::*;

    // ----------------------------------------
    // Transfer
    // ----------------------------------------
    initial begin
        cmd_valid = 1'b0;
        cmd_code = TCT_CMD_READ_TEMP;
        cmd_write = 1'b0;
        cmd_wdata = 16'h0000;
    end

    // Strobe held across one rising edge; answer sampled a cycle later
    task automatic xfer(input tct_cmd_t c, input logic w, input logic [15:0] d, output logic [15:0] q,
        output logic v);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_code = c;
        cmd_write = w;
        cmd_wdata = d;
        @(negedge clk);
        q = cmd_rdata;
        v = cmd_rvalid;
        cmd_valid = 1'b0;
        cmd_wdata = ~d; // Stale data never looks valid
    endtask
endmodule
